// ### rtl/mpc_defs.svh
// Constants for the mode parameter capacity and error recovery controller.
// Function
// R1: Sense data length counts page bytes only.
// R2: Medium type byte always reads zero.
// R3: Write protect bit follows select control bit.
// R4: DPOFUA header bit always reads zero.
// R5: Device specific bits and density code zero.
// R6: Block descriptor length is zero or eight.
// R7: Sense returns zero blocks, configured block length.
// R8: Select block count sets working capacity.
// R9: Count above maximum gives illegal address.
// R10: Access beyond working capacity gives illegal address.
// R11: Capacity saved only when save bit set.
// R12: Block length change restores maximum capacity.
// R13: Page save bit one; ignored on select.
// R14: Page length counts bytes after it.
// R15: Recovery page length six or ten.
// R16: Reallocation and transfer flags default zero, changeable.
// R17: Continuous, early, offset counts fixed zero.
// R18: Post error flag defaults one, changeable.
// R19: Inverted disable flags default zero, changeable.
// R20: Retry counts default eight, changeable.
// R21: Correction span 0, 18h or 48h only.
// R22: Time limit FF old, 0000 changeable new.
// R23: Sense transfer stops at allocation or data end.
`ifndef MPC_DEFS_SVH
`define MPC_DEFS_SVH

// ----------------------------------------------------------------
// Layout
// ----------------------------------------------------------------
`define MPC_HDR6_LEN      16'h0004
`define MPC_HDR10_LEN     16'h0008
`define MPC_BD_LEN        16'h0008
`define MPC_PG_OLD_TOTAL  16'h0008
`define MPC_PG_NEW_TOTAL  16'h000C
`define MPC_PG_OLD_LEN    8'h06
`define MPC_PG_NEW_LEN    8'h0A
`define MPC_PG_ERP        6'h01
`define MPC_PG_NONE       6'h00
`define MPC_PG_ALL        6'h3F
`define MPC_OLD_TLIMIT    8'hFF

// ----------------------------------------------------------------
// Capacity and defaults
// ----------------------------------------------------------------
`define MPC_NB_MAXSEL     24'h0F_FFFF
`define MPC_NB_KEEP       24'h00_0000
`define MPC_DEF_RETRY     8'h08
`define MPC_DEF_SPAN      8'h48
`define MPC_ALT_SPAN      8'h18
`define MPC_ZERO_SPAN     8'h00

// ----------------------------------------------------------------
// Page control and status codes
// ----------------------------------------------------------------
`define MPC_PC_CUR        2'h0
`define MPC_PC_CHG        2'h1
`define MPC_PC_DEF        2'h2
`define MPC_PC_SAV        2'h3
`define MPC_SK_NONE       4'h0
`define MPC_SK_ILLEGAL    4'h5
`define MPC_ASC_NONE      8'h00
`define MPC_ASC_BAD_LBA   8'h21
`define MPC_ASC_BAD_CDB   8'h24
`define MPC_ASC_BAD_PARM  8'h26

`endif

// ### rtl/mpc_pkg.sv
// Types shared by the mode parameter controller modules.
package mpc_pkg;

  typedef enum logic [1:0] {
    MPC_IDLE,
    MPC_SENSE,
    MPC_SELECT,
    MPC_COMMIT
  } mpc_state_t;

  typedef struct packed {
    logic        awre;
    logic        arre;
    logic        tb;
    logic        per;
    logic        dte;
    logic        dcr;
    logic [7:0]  rd_retry;
    logic [7:0]  corr_span;
    logic [7:0]  wr_retry;
    logic [15:0] rec_limit;
  } mpc_erp_t;

endpackage

// ### rtl/mpc_sense_byte.sv
// Byte generator for the mode sense data stream.
`timescale 1ns/10ps
`include "mpc_defs.svh"
module mpc_sense_byte
  import mpc_pkg::*;
(
  input  wire logic [4:0]  idx_i,
  input  wire logic        ten_i,
  input  wire logic        bd_on_i,
  input  wire logic        page_on_i,
  input  wire logic        scsi2_i,
  input  wire logic        chg_i,
  input  wire logic        wp_i,
  input  wire logic [23:0] blk_len_i,
  input  wire mpc_erp_t    erp_i,
  output logic      [7:0]  byte_o
);

  logic [4:0] hdr;
  logic [4:0] bd_end;
  logic [4:0] q;
  logic [4:0] p;
  logic [7:0] sdl;
  logic [7:0] flags;

  always_comb begin
    hdr    = ten_i ? 5'(`MPC_HDR10_LEN) : 5'(`MPC_HDR6_LEN);
    bd_end = hdr + (bd_on_i ? 5'(`MPC_BD_LEN) : 5'h00);
    q      = idx_i - hdr;
    p      = idx_i - bd_end;
    sdl    = page_on_i ? (scsi2_i ? 8'(`MPC_PG_NEW_TOTAL) : 8'(`MPC_PG_OLD_TOTAL)) : 8'h00; // R1
    flags  = {wp_i, 2'b00, 1'b0, 4'h0}; // R3 R4 R5
    byte_o = 8'h00; // R2 R5
    if (idx_i < hdr) begin
      if (ten_i) begin
        case (idx_i[2:0])
          3'h1: byte_o = sdl;
          3'h3: byte_o = flags;
          3'h7: byte_o = bd_on_i ? 8'(`MPC_BD_LEN) : 8'h00; // R6
          default: byte_o = 8'h00;
        endcase
      end else begin
        case (idx_i[1:0])
          2'h0: byte_o = sdl;
          2'h2: byte_o = flags;
          2'h3: byte_o = bd_on_i ? 8'(`MPC_BD_LEN) : 8'h00; // R6
          default: byte_o = 8'h00;
        endcase
      end
    end else if (idx_i < bd_end) begin
      case (q[2:0])
        3'h5: byte_o = blk_len_i[23:16]; // R7
        3'h6: byte_o = blk_len_i[15:8];
        3'h7: byte_o = blk_len_i[7:0];
        default: byte_o = 8'h00; // R7
      endcase
    end else begin
      case (p[3:0])
        4'h0: byte_o = {1'b1, 1'b0, `MPC_PG_ERP}; // R13
        4'h1: byte_o = scsi2_i ? `MPC_PG_NEW_LEN : `MPC_PG_OLD_LEN; // R14 R15
        4'h2: byte_o = {erp_i.awre, erp_i.arre, erp_i.tb, 2'b00, erp_i.per, erp_i.dte, erp_i.dcr}; // R17
        4'h3: byte_o = erp_i.rd_retry;
        4'h4: byte_o = erp_i.corr_span;
        4'h7: byte_o = (scsi2_i || chg_i) ? 8'h00 : `MPC_OLD_TLIMIT; // R22
        4'h8: byte_o = erp_i.wr_retry;
        4'hA: byte_o = erp_i.rec_limit[15:8];
        4'hB: byte_o = erp_i.rec_limit[7:0];
        default: byte_o = 8'h00; // R17
      endcase
    end
  end

endmodule

// ### rtl/mpc_mode_ctrl.sv
// Mode sense and select controller for capacity and error recovery page.
`timescale 1ns/10ps
`include "mpc_defs.svh"
module mpc_mode_ctrl
  import mpc_pkg::*;
#(
  parameter logic [23:0] MAX_BLOCKS  = 24'h08_0000,
  parameter logic [23:0] DEF_BLK_LEN = 24'h00_0200
)
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        scsi2_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_sense_i,
  input  wire logic        cmd_ten_i,
  input  wire logic        cmd_dbd_i,
  input  wire logic [1:0]  cmd_pc_i,
  input  wire logic [5:0]  cmd_page_i,
  input  wire logic [15:0] cmd_alloc_i,
  input  wire logic        cmd_save_i,
  input  wire logic        cmd_wp_i,
  output logic             cmd_ready_o,
  output logic             din_valid_o,
  output logic      [7:0]  din_data_o,
  input  wire logic        din_ready_i,
  input  wire logic        dout_valid_i,
  input  wire logic [7:0]  dout_data_i,
  input  wire logic        dout_last_i,
  output logic             dout_ready_o,
  output logic             done_o,
  output logic             check_o,
  output logic      [3:0]  sense_key_o,
  output logic      [7:0]  asc_o,
  input  wire logic        fmt_bytes_chg_i,
  input  wire logic        nv_valid_i,
  input  wire logic [23:0] nv_cap_i,
  output logic             nv_wr_o,
  output logic      [23:0] nv_cap_o,
  input  wire logic        acc_valid_i,
  input  wire logic [23:0] acc_lba_i,
  input  wire logic [15:0] acc_cnt_i,
  output logic             acc_resp_o,
  output logic             acc_illegal_o,
  output logic      [23:0] capacity_o,
  output logic      [23:0] blk_len_o,
  output logic             wp_o,
  output logic             awre_o,
  output logic             arre_o,
  output logic             tb_o,
  output logic             per_o,
  output logic             dte_o,
  output logic             dcr_o,
  output logic      [7:0]  rd_retry_o,
  output logic      [7:0]  wr_retry_o,
  output logic      [7:0]  corr_span_o,
  output logic      [15:0] rec_limit_o
);

  // ----------------------------------------------------------------
  // Elaboration checks and constant page sets
  // ----------------------------------------------------------------
  if (MAX_BLOCKS == 24'h00_0000 || MAX_BLOCKS >= `MPC_NB_MAXSEL) begin : g_bad_max
    $error("MAX_BLOCKS must be nonzero and below the maximum select code");
  end

  localparam mpc_erp_t ERP_DEF = '{awre: 1'b0, arre: 1'b0, tb: 1'b0, per: 1'b1, dte: 1'b0, dcr: 1'b0, // R16 R18 R19
                                   rd_retry: `MPC_DEF_RETRY, corr_span: `MPC_DEF_SPAN, // R20 R21
                                   wr_retry: `MPC_DEF_RETRY, rec_limit: 16'h0000}; // R22
  localparam mpc_erp_t ERP_CHG = '{awre: 1'b1, arre: 1'b1, tb: 1'b1, per: 1'b1, dte: 1'b1, dcr: 1'b1,
                                   rd_retry: 8'hFF, corr_span: 8'hFF, wr_retry: 8'hFF, rec_limit: 16'hFFFF};

  function automatic mpc_erp_t merge_erp(input mpc_erp_t cur, input mpc_erp_t upd, input mpc_erp_t msk);
    merge_erp = (cur & ~msk) | (upd & msk);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mpc_state_t  state;
  mpc_erp_t    cur_erp;
  mpc_erp_t    sav_erp;
  mpc_erp_t    sel_erp;
  mpc_erp_t    gen_erp;
  logic [15:0] idx;
  logic [15:0] xfer_n;
  logic        s_ten;
  logic        s_bd_on;
  logic        s_page_on;
  logic        s_chg;
  logic        s_save;
  logic        s_wp;
  logic [1:0]  s_pc;
  logic [15:0] sel_bdl;
  logic [5:0]  sel_pcode;
  logic        sel_bd_seen;
  logic [23:0] sel_nb;
  logic [23:0] sel_bl;
  logic        booted;
  logic [15:0] hdr_len;
  logic [15:0] bd_end;
  logic [15:0] q;
  logic [15:0] p;
  logic [15:0] total;
  logic [15:0] next_xfer;
  logic        page_ok;
  logic        page_on;
  logic        span_bad;
  logic        nb_bad;
  logic        bl_chg;
  logic [23:0] next_cap;
  logic [4:0]  gen_idx;
  logic [7:0]  gen_byte;
  logic        take_cmd;
  logic        adv;

  assign cmd_ready_o  = (state == MPC_IDLE);
  assign din_valid_o  = (state == MPC_SENSE);
  assign dout_ready_o = (state == MPC_SELECT);
  assign take_cmd     = clk_en_i && cmd_valid_i && (state == MPC_IDLE);
  assign adv          = clk_en_i && din_ready_i && (state == MPC_SENSE);

  // ----------------------------------------------------------------
  // Command decode and sizing
  // ----------------------------------------------------------------
  always_comb begin
    page_ok   = (cmd_page_i == `MPC_PG_NONE) || (cmd_page_i == `MPC_PG_ERP) || (cmd_page_i == `MPC_PG_ALL);
    page_on   = (cmd_page_i != `MPC_PG_NONE);
    total     = (cmd_ten_i ? `MPC_HDR10_LEN : `MPC_HDR6_LEN) + (cmd_dbd_i ? 16'h0000 : `MPC_BD_LEN)
              + (page_on ? (scsi2_i ? `MPC_PG_NEW_TOTAL : `MPC_PG_OLD_TOTAL) : 16'h0000);
    next_xfer = (cmd_alloc_i < total) ? cmd_alloc_i : total; // R23
    hdr_len   = s_ten ? `MPC_HDR10_LEN : `MPC_HDR6_LEN;
    bd_end    = hdr_len + sel_bdl;
    q         = idx - hdr_len;
    p         = idx - bd_end;
    span_bad  = (sel_erp.corr_span != `MPC_ZERO_SPAN) && (sel_erp.corr_span != `MPC_ALT_SPAN)
             && (sel_erp.corr_span != `MPC_DEF_SPAN); // R21
    nb_bad    = (sel_nb != `MPC_NB_KEEP) && (sel_nb != `MPC_NB_MAXSEL) && (sel_nb > MAX_BLOCKS); // R9
    bl_chg    = sel_bd_seen && (sel_bl != blk_len_o);
    if (bl_chg || sel_nb == `MPC_NB_MAXSEL) begin
      next_cap = MAX_BLOCKS; // R8 R12
    end else if (sel_nb == `MPC_NB_KEEP) begin
      next_cap = capacity_o; // R8
    end else begin
      next_cap = sel_nb; // R8
    end
    case (s_pc)
      `MPC_PC_CHG: gen_erp = ERP_CHG;
      `MPC_PC_DEF: gen_erp = ERP_DEF;
      `MPC_PC_SAV: gen_erp = sav_erp;
      default:     gen_erp = cur_erp;
    endcase
    gen_idx = (state == MPC_SENSE) ? 5'(idx + 16'h0001) : 5'h00;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= MPC_IDLE;
      idx   <= 16'h0000;
    end else if (clk_en_i) begin
      case (state)
        MPC_IDLE: begin
          idx <= 16'h0000;
          if (cmd_valid_i) begin
            if (!cmd_sense_i) begin
              state <= MPC_SELECT;
            end else if (page_ok && next_xfer != 16'h0000) begin
              state <= MPC_SENSE; // R23
            end
          end
        end
        MPC_SENSE: begin
          if (din_ready_i) begin
            if (idx + 16'h0001 >= xfer_n) begin
              state <= MPC_IDLE; // R23
            end
            idx <= idx + 16'h0001;
          end
        end
        MPC_SELECT: begin
          if (dout_valid_i) begin
            idx <= idx + 16'h0001;
            if (dout_last_i) begin
              state <= MPC_COMMIT;
            end
          end
        end
        MPC_COMMIT: state <= MPC_IDLE;
        default:    state <= MPC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Latched command fields and sense data output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ten      <= 1'b0;
      s_bd_on    <= 1'b0;
      s_page_on  <= 1'b0;
      s_chg      <= 1'b0;
      s_save     <= 1'b0;
      s_wp       <= 1'b0;
      s_pc       <= `MPC_PC_CUR;
      xfer_n     <= 16'h0000;
      din_data_o <= 8'h00;
    end else if (clk_en_i) begin
      if (take_cmd) begin
        s_ten     <= cmd_ten_i;
        s_bd_on   <= !cmd_dbd_i; // R6
        s_page_on <= page_on;
        s_chg     <= (cmd_pc_i == `MPC_PC_CHG);
        s_save    <= cmd_save_i; // R11
        s_wp      <= cmd_wp_i; // R3
        s_pc      <= cmd_pc_i;
        xfer_n    <= next_xfer; // R23
        din_data_o <= gen_byte;
      end
      if (adv) begin
        din_data_o <= gen_byte;
      end
    end
  end

  // The latched fields are only ready one cycle after acceptance, while valid is already up,
  // so the generator is fed from the live command inputs for index zero.
  mpc_sense_byte u_gen (
    .idx_i     (gen_idx),
    .ten_i     (state == MPC_SENSE ? s_ten : cmd_ten_i),
    .bd_on_i   (state == MPC_SENSE ? s_bd_on : !cmd_dbd_i),
    .page_on_i (state == MPC_SENSE ? s_page_on : page_on),
    .scsi2_i   (scsi2_i),
    .chg_i     (s_chg),
    .wp_i      (wp_o),
    .blk_len_i (blk_len_o),
    .erp_i     (gen_erp),
    .byte_o    (gen_byte)
  );

  // ----------------------------------------------------------------
  // Select parameter parsing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_erp     <= ERP_DEF;
      sel_bdl     <= 16'h0000;
      sel_pcode   <= `MPC_PG_NONE;
      sel_bd_seen <= 1'b0;
      sel_nb      <= `MPC_NB_KEEP;
      sel_bl      <= DEF_BLK_LEN;
    end else if (clk_en_i) begin
      if (take_cmd) begin
        sel_erp     <= cur_erp;
        sel_bdl     <= 16'h0000;
        sel_pcode   <= `MPC_PG_NONE;
        sel_bd_seen <= 1'b0;
        sel_nb      <= `MPC_NB_KEEP;
        sel_bl      <= blk_len_o;
      end else if (state == MPC_SELECT && dout_valid_i) begin
        if (idx < hdr_len) begin
          if (idx == hdr_len - 16'h0002 && s_ten) sel_bdl[15:8] <= dout_data_i;
          if (idx == hdr_len - 16'h0001) sel_bdl[7:0] <= dout_data_i;
        end else if (idx < bd_end) begin
          sel_bd_seen <= 1'b1;
          case (q)
            16'h0001: sel_nb[23:16] <= dout_data_i;
            16'h0002: sel_nb[15:8]  <= dout_data_i;
            16'h0003: sel_nb[7:0]   <= dout_data_i;
            16'h0005: sel_bl[23:16] <= dout_data_i;
            16'h0006: sel_bl[15:8]  <= dout_data_i;
            16'h0007: sel_bl[7:0]   <= dout_data_i;
            default: ;
          endcase
        end else if (p == 16'h0000) begin
          sel_pcode <= dout_data_i[5:0]; // R13
        end else if (sel_pcode == `MPC_PG_ERP) begin
          case (p)
            16'h0002: {sel_erp.awre, sel_erp.arre, sel_erp.tb} <= dout_data_i[7:5]; // R16
            16'h0003: sel_erp.rd_retry  <= dout_data_i; // R20
            16'h0004: sel_erp.corr_span <= dout_data_i; // R21
            16'h0008: sel_erp.wr_retry  <= scsi2_i ? dout_data_i : sel_erp.wr_retry; // R20
            16'h000A: sel_erp.rec_limit[15:8] <= scsi2_i ? dout_data_i : sel_erp.rec_limit[15:8]; // R22
            16'h000B: sel_erp.rec_limit[7:0]  <= scsi2_i ? dout_data_i : sel_erp.rec_limit[7:0]; // R22
            default: ;
          endcase
          if (p == 16'h0002) begin
            {sel_erp.per, sel_erp.dte, sel_erp.dcr} <= dout_data_i[2:0]; // R18 R19
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Commit of page values, block length and write protect
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_erp   <= ERP_DEF;
      sav_erp   <= ERP_DEF;
      blk_len_o <= DEF_BLK_LEN;
      wp_o      <= 1'b0;
    end else if (clk_en_i && state == MPC_COMMIT && !span_bad && !nb_bad) begin
      cur_erp   <= merge_erp(cur_erp, sel_erp, ERP_CHG); // R17
      sav_erp   <= s_save ? merge_erp(cur_erp, sel_erp, ERP_CHG) : sav_erp;
      blk_len_o <= sel_bl;
      wp_o      <= s_wp; // R3
    end
  end

  // ----------------------------------------------------------------
  // Working capacity and its nonvolatile copy
  // ----------------------------------------------------------------
  // The stored capacity is taken once after reset release, since an asynchronous reset may load no input.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      capacity_o <= MAX_BLOCKS;
      booted     <= 1'b0;
      nv_wr_o    <= 1'b0;
      nv_cap_o   <= MAX_BLOCKS;
    end else if (clk_en_i) begin
      nv_wr_o <= 1'b0;
      booted  <= 1'b1;
      if (!booted && nv_valid_i && nv_cap_i != `MPC_NB_KEEP && nv_cap_i <= MAX_BLOCKS) begin
        capacity_o <= nv_cap_i;
      end else if (state == MPC_COMMIT && !span_bad && !nb_bad) begin
        capacity_o <= next_cap; // R8 R12
        nv_wr_o    <= s_save; // R11
        nv_cap_o   <= next_cap;
      end else if (fmt_bytes_chg_i) begin
        capacity_o <= MAX_BLOCKS; // R12
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion status
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o      <= 1'b0;
      check_o     <= 1'b0;
      sense_key_o <= `MPC_SK_NONE;
      asc_o       <= `MPC_ASC_NONE;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      if (take_cmd && cmd_sense_i && (!page_ok || next_xfer == 16'h0000)) begin
        done_o      <= 1'b1; // R23
        check_o     <= !page_ok;
        sense_key_o <= page_ok ? `MPC_SK_NONE : `MPC_SK_ILLEGAL;
        asc_o       <= page_ok ? `MPC_ASC_NONE : `MPC_ASC_BAD_CDB;
      end else if (adv && idx + 16'h0001 >= xfer_n) begin
        done_o      <= 1'b1;
        check_o     <= 1'b0;
        sense_key_o <= `MPC_SK_NONE;
        asc_o       <= `MPC_ASC_NONE;
      end else if (clk_en_i && state == MPC_COMMIT) begin
        done_o      <= 1'b1;
        check_o     <= span_bad || nb_bad; // R9
        sense_key_o <= (span_bad || nb_bad) ? `MPC_SK_ILLEGAL : `MPC_SK_NONE;
        asc_o       <= span_bad ? `MPC_ASC_BAD_PARM : (nb_bad ? `MPC_ASC_BAD_LBA : `MPC_ASC_NONE); // R9
      end
    end
  end

  // ----------------------------------------------------------------
  // Access range check
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_resp_o    <= 1'b0;
      acc_illegal_o <= 1'b0;
    end else if (clk_en_i) begin
      acc_resp_o <= acc_valid_i;
      if (acc_valid_i) begin
        acc_illegal_o <= ({1'b0, acc_lba_i} + {9'h000, acc_cnt_i}) > {1'b0, capacity_o}; // R10
      end
    end
  end

  assign awre_o      = cur_erp.awre;
  assign arre_o      = cur_erp.arre;
  assign tb_o        = cur_erp.tb;
  assign per_o       = cur_erp.per;
  assign dte_o       = cur_erp.dte;
  assign dcr_o       = cur_erp.dcr;
  assign rd_retry_o  = cur_erp.rd_retry;
  assign wr_retry_o  = cur_erp.wr_retry;
  assign corr_span_o = cur_erp.corr_span;
  assign rec_limit_o = cur_erp.rec_limit;

endmodule

// ### tb/mpc_host.sv
// Initiator model that takes mode sense bytes with random stalls.
`timescale 1ns/10ps
module mpc_host (
  input  wire logic core_clk_i,
  input  wire logic din_valid_i,
  output logic      din_ready_o
);
  int seed = 78;
  initial din_ready_o = 1'b0;
  // A real initiator may pause the data in phase at any byte.
  always @(negedge core_clk_i) din_ready_o <= din_valid_i & 1'($random(seed));
endmodule

// ### tb/mpc_mode_ctrl_assertions.sv
// Port checker for the mode parameter controller.
`timescale 1ns/10ps
module mpc_chk #(
  parameter logic [23:0] MAX_BLOCKS = 24'h08_0000
) (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        clk_en_i,
  input wire logic        cmd_ready_o,
  input wire logic        din_valid_o,
  input wire logic [7:0]  din_data_o,
  input wire logic        din_ready_i,
  input wire logic        done_o,
  input wire logic        check_o,
  input wire logic [3:0]  sense_key_o,
  input wire logic        acc_valid_i,
  input wire logic [23:0] acc_lba_i,
  input wire logic [15:0] acc_cnt_i,
  input wire logic        acc_resp_o,
  input wire logic        acc_illegal_o,
  input wire logic [23:0] capacity_o,
  input wire logic [7:0]  corr_span_o,
  input wire logic        fmt_bytes_chg_i,
  input wire logic        nv_wr_o,
  input wire logic [23:0] nv_cap_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff rst_i;
  a_din_hold: assert property (din_valid_o && !din_ready_i && clk_en_i |=> din_valid_o && $stable(din_data_o))
    else $error("sense byte changed before acceptance");
  a_din_busy: assert property (din_valid_o |-> !cmd_ready_o && !done_o)
    else $error("sense stream overlaps idle or done");
  a_cap_bound: assert property (capacity_o <= MAX_BLOCKS)
    else $error("capacity above maximum");
  a_check_key: assert property (check_o |-> sense_key_o == 4'h5)
    else $error("check without illegal request key");
  a_acc_range: assert property (acc_valid_i && clk_en_i |=> acc_resp_o &&
    acc_illegal_o == ({1'b0, $past(acc_lba_i)} + $past(acc_cnt_i) > $past(capacity_o)))
    else $error("access range verdict wrong");
  a_span_legal: assert property (corr_span_o inside {8'h00, 8'h18, 8'h48})
    else $error("correction span out of set");
  a_fmt_max: assert property (fmt_bytes_chg_i && clk_en_i && cmd_ready_o |=> capacity_o == MAX_BLOCKS)
    else $error("format change kept capacity");
  a_save_done: assert property (nv_wr_o |-> done_o && !check_o && nv_cap_o == capacity_o)
    else $error("save request without good select");
  c_stall: cover property (din_valid_o && !din_ready_i);
  c_save: cover property (nv_wr_o);
  c_illegal: cover property (acc_resp_o && acc_illegal_o);
endmodule
bind mpc_mode_ctrl mpc_chk #(.MAX_BLOCKS(MAX_BLOCKS)) chk_i (.*);

// ### tb/tb.sv
// Self-checking bench for the mode parameter controller.
`timescale 1ns/10ps
module tb;
  import mpc_pkg::*;
  localparam logic [23:0] MAXB = 24'h08_0000;
  logic core_clk_i, rst_i, clk_en_i, scsi2_i, cmd_valid_i, cmd_sense_i, cmd_ten_i, cmd_dbd_i;
  logic cmd_save_i, cmd_wp_i, din_ready_i, dout_valid_i, dout_last_i, fmt_bytes_chg_i, nv_valid_i, acc_valid_i;
  logic cmd_ready_o, din_valid_o, dout_ready_o, done_o, check_o, nv_wr_o, acc_resp_o, acc_illegal_o;
  logic wp_o, awre_o, arre_o, tb_o, per_o, dte_o, dcr_o, dn, nvw;
  logic [1:0]  cmd_pc_i;
  logic [3:0]  sense_key_o;
  logic [5:0]  cmd_page_i;
  logic [7:0]  dout_data_i, din_data_o, asc_o, rd_retry_o, wr_retry_o, corr_span_o;
  logic [15:0] cmd_alloc_i, acc_cnt_i, rec_limit_o;
  logic [23:0] nv_cap_i, acc_lba_i, nv_cap_o, capacity_o, blk_len_o, r;
  logic [7:0]  q[$], sq[$];
  int          n_fail = 0, cmp_count = 0, cyc = 0, seed = 78;
  mpc_mode_ctrl #(.MAX_BLOCKS(MAXB)) dut (.*);
  mpc_host host (.core_clk_i(core_clk_i), .din_valid_i(din_valid_o), .din_ready_o(din_ready_i));
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task end_sim;
    $display("checks %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmd(input logic s, t, d, input logic [1:0] pc, input logic [5:0] pg, input logic [15:0] al);
    {cmd_sense_i, cmd_ten_i, cmd_dbd_i, cmd_pc_i, cmd_page_i, cmd_alloc_i} = {s, t, d, pc, pg, al};
    cmd_valid_i = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    if (!s) foreach (sq[i]) begin
      {dout_valid_i, dout_data_i, dout_last_i} = {1'b1, sq[i], (i == sq.size() - 1)};
      while (dout_ready_o !== 1'b1) @(negedge core_clk_i);
      @(negedge core_clk_i);
    end
    dout_valid_i = 1'b0;
    for (int i = 0; i < 500 && done_o !== 1'b1; i++) @(negedge core_clk_i);
    {dn, nvw} = {done_o, nv_wr_o};
    @(negedge core_clk_i);
    chk(dn, 1'b1);
  endtask
  // Every select carries the same page except the rejected span 30h, so the page outputs never move after the first one.
  task automatic sel(input logic [23:0] nb, input logic sv, ck, input logic [7:0] as, sp, input logic [23:0] cp);
    sq = {8'h00, 8'h00, 8'h00, 8'h08, 8'h00, nb[23:16], nb[15:8], nb[7:0], 8'h00, 8'h00, 8'h02, 8'h00,
          8'h81, 8'h0A, 8'hA0, 8'hFF, sp, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    cmd_save_i = sv;
    cmd(1'b0, 1'b0, 1'b0, 2'h0, 6'h01, 16'h0000);
    chk({check_o, sense_key_o, asc_o}, {ck, 1'b0, ck, 1'b0, ck, as});
    chk(capacity_o, cp);
    chk(nvw, sv & !ck);
    chk({awre_o, arre_o, tb_o, per_o, dte_o, dcr_o, corr_span_o, rd_retry_o, wr_retry_o}, 30'h28_18FF00);
  endtask
  task automatic acc(input logic [23:0] l, input logic [15:0] c, input logic e);
    {acc_valid_i, acc_lba_i, acc_cnt_i} = {1'b1, l, c};
    @(negedge core_clk_i);
    acc_valid_i = 1'b0;
    chk({acc_resp_o, acc_illegal_o}, {1'b1, e});
    @(negedge core_clk_i);
  endtask
  always @(posedge core_clk_i)
    if (din_valid_o === 1'b1 && din_ready_i === 1'b1) begin
      if (q.size() == 0) chk(din_data_o, 32'hFFFF_FFFF);
      else chk(din_data_o, q.pop_front());
    end
  always @(posedge core_clk_i) if (++cyc == 20000) begin
    n_fail++;
    end_sim;
  end
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    {cmd_valid_i, cmd_sense_i, cmd_ten_i, cmd_dbd_i, cmd_pc_i, cmd_page_i, cmd_alloc_i, cmd_save_i} = '0;
    {cmd_wp_i, dout_valid_i, dout_data_i, dout_last_i, fmt_bytes_chg_i, acc_valid_i, acc_lba_i, acc_cnt_i} = '0;
    {rst_i, clk_en_i, scsi2_i, nv_valid_i, nv_cap_i} = {4'hF, 24'h00_1234};
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk(capacity_o, 24'h00_1234);
    q = {8'h0C, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00,
         8'h81, 8'h0A, 8'h04, 8'h08, 8'h48, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
    cmd(1'b1, 1'b0, 1'b0, 2'h2, 6'h01, 16'h00FF);
    chk(q.size(), 0);
    chk(blk_len_o, 24'h00_0200);
    cmd_wp_i = 1'b1;
    r = 24'($random(seed)) % MAXB + 24'h00_0001;
    sel(r, 1'b1, 1'b0, 8'h00, 8'h18, r);
    chk(wp_o, 1'b1);
    sel(MAXB + 24'h00_0001, 1'b1, 1'b1, 8'h21, 8'h18, r);
    acc(r - 24'h00_0001, 16'h0001, 1'b0);
    acc(r, 16'h0001, 1'b1);
    fmt_bytes_chg_i = 1'b1;
    @(negedge core_clk_i);
    fmt_bytes_chg_i = 1'b0;
    chk(capacity_o, MAXB);
    sel(r, 1'b0, 1'b0, 8'h00, 8'h18, r);
    sel(24'h00_0000, 1'b0, 1'b0, 8'h00, 8'h18, r);
    sel(24'h0F_FFFF, 1'b0, 1'b0, 8'h00, 8'h18, MAXB);
    sel(MAXB, 1'b0, 1'b1, 8'h26, 8'h30, MAXB);
    scsi2_i = 1'b0;
    q = {8'h00, 8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h06, 8'hA0, 8'hFF, 8'h18, 8'h00,
         8'h00, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h80, 8'h00};
    cmd(1'b1, 1'b1, 1'b1, 2'h3, 6'h3F, 16'h0020);
    cmd(1'b1, 1'b1, 1'b1, 2'h0, 6'h3F, 16'h0005);
    chk(q.size(), 0);
    cmd(1'b1, 1'b0, 1'b0, 2'h0, 6'h01, 16'h0000);
    chk(check_o, 1'b0);
    end_sim;
  end
endmodule
